// ==== hvat_chk.sv ====
`timescale 1ns/1ps
// ==========================================
// Port checker for the assist block
module hvat_chk (
	input logic        clk_sys,
	input logic        rst_n,
	input logic [3:0]  reg_addr,
	input logic [31:0] reg_wdata,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [31:0] reg_rdata,
	input logic        instr_valid,
	input logic [47:0] instr,
	input logic [2:0]  instr_len,
	input logic        supervisor_state,
	input logic        xa_mode,
	input logic        host_timer_int_en,
	input logic        guest_timer_int_en,
	input logic        exec_valid,
	input logic [2:0]  exec_func,
	input logic        nop_done,
	input logic        op_exception,
	input logic        priv_exception,
	input logic        store_valid,
	input logic        guest_int_req,
	input logic        host_int_req,
	input logic [15:0] int_code
);
	logic host_en;
	logic asst;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Assist instruction seen
	assign asst = instr_valid && instr[47:40] == 8'hE6 && instr_len == 3'h6;
	// Shadow of host-routine enable
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			host_en <= 1'b0;
		else if (reg_wr && reg_addr == 4'h0)
			host_en <= reg_wdata[25];
	end
	AST_PRIV: assert property (asst && !supervisor_state |=> priv_exception)
		else $error("missing privilege exception");
	AST_NOP: assert property (asst && supervisor_state && !(xa_mode && host_en) |=> nop_done)
		else $error("missing nop completion");
	AST_EXEC: assert property (asst && supervisor_state && xa_mode && host_en
		&& instr[39:32] <= 8'h06 |=> exec_valid && exec_func == $past(instr[34:32]))
		else $error("wrong executed function");
	AST_BADOP: assert property (asst && supervisor_state && xa_mode && host_en
		&& instr[39:32] > 8'h06 |=> op_exception && !exec_valid)
		else $error("unknown function not refused");
	AST_STORE: assert property (store_valid |-> exec_valid && exec_func == 3'h4)
		else $error("stray store");
	AST_RDZERO: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");
	AST_GCODE: assert property (guest_int_req |-> int_code == 16'h0080 && !host_int_req)
		else $error("bad guest request");
	AST_HCODE: assert property (host_int_req |-> int_code == 16'h0082 && $past(host_timer_int_en))
		else $error("bad host request");
	AST_GEN: assert property (guest_int_req |-> $past(guest_timer_int_en))
		else $error("guest request while disabled");
	COV_EXEC: cover property (exec_valid && exec_func == 3'h4);
	COV_GUEST: cover property (guest_int_req);
	COV_HOST: cover property (host_int_req);
endmodule // hvat_chk

// ==== hvat_decode.v ====
`timescale 1ns/1ps
`include "hvat_defs.vh"

// Assist instruction decoder: classifies a six-byte instruction
module hvat_decode (
	input  wire [47:0] instr,
	input  wire        instr_len_ok,
	input  wire        feature_installed,
	input  wire        host_assist_en,
	input  wire        supervisor_state,
	output reg         is_assist,
	output reg  [2:0]  func_sel,
	output reg  [1:0]  outcome
);
	// ==========================================================
	// Opcode and extended opcode lookup
	always @* begin
		is_assist = instr_len_ok && (instr[47:40] == `HVAT_ASSIST_OPCODE);
		case (instr[39:32])
			`HVAT_XOP_FREE_STOR:  func_sel = 3'h0;
			`HVAT_XOP_VIO_BLOCKS: func_sel = 3'h1;
			`HVAT_XOP_INV_SEG:    func_sel = 3'h2;
			`HVAT_XOP_INV_PAGE:   func_sel = 3'h3;
			`HVAT_XOP_STORE_LVL:  func_sel = 3'h4;
			`HVAT_XOP_SVC_LINK:   func_sel = 3'h5;
			`HVAT_XOP_SVC_RETURN: func_sel = 3'h6;
			default:              func_sel = 3'h7;
		endcase
		// Feature missing traps first, then state, then enable
		if (!feature_installed)
			outcome = `HVAT_OUT_OPEXC;
		else if (!supervisor_state)
			outcome = `HVAT_OUT_PRIV;
		else if (host_assist_en)
			outcome = `HVAT_OUT_EXECUTE;
		else
			outcome = `HVAT_OUT_NOP;
	end
endmodule // hvat_decode

// ==== hvat_defs.vh ====
`ifndef HVAT_DEFS_VH
`define HVAT_DEFS_VH

// ==========================================================
// Register map (word offsets on the plain register port)
`define HVAT_REG_CTRL6      4'h0
`define HVAT_REG_STATUS     4'h1
`define HVAT_REG_VTIMER     4'h2
`define HVAT_REG_BLOCK_TMR  4'h3
`define HVAT_REG_LEVEL      4'h4
`define HVAT_REG_INT_CODE   4'h5

// ==========================================================
// Control register 6 assist enable bits (bit 0 is the msb, 32-bit word)
`define HVAT_CR6_BIT0_POS   31
`define HVAT_CR6_BIT6_POS   25
`define HVAT_CR6_BIT7_POS   24
`define HVAT_CR6_RESET      32'h0000_0000

// ==========================================================
// Instruction decode
`define HVAT_INSTR_BYTES    3'h6
`define HVAT_ASSIST_OPCODE  8'hE6
`define HVAT_XOP_FREE_STOR  8'h00
`define HVAT_XOP_VIO_BLOCKS 8'h01
`define HVAT_XOP_INV_SEG    8'h02
`define HVAT_XOP_INV_PAGE   8'h03
`define HVAT_XOP_STORE_LVL  8'h04
`define HVAT_XOP_SVC_LINK   8'h05
`define HVAT_XOP_SVC_RETURN 8'h06

// Outcome codes of an assist instruction
`define HVAT_OUT_EXECUTE    2'h0
`define HVAT_OUT_NOP        2'h1
`define HVAT_OUT_OPEXC      2'h2
`define HVAT_OUT_PRIV       2'h3

// ==========================================================
// Timer
`define HVAT_VTIMER_ADDR    12'h050
`define HVAT_VTIMER_STEP    32'h0000_0100
`define HVAT_EXT_CODE_VIRT  16'h0082
`define HVAT_EXT_CODE_REAL  16'h0080
`define HVAT_WAIT_DIV       8'h04

`endif

// ==== hvat_top.v ====
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "hvat_defs.vh"

module hvat_top #(
	parameter [31:0] LEVEL_ID          = 32'h0000_0001, // Arbitrary level value
	parameter        FEATURE_INSTALLED = 1
) (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	input  wire        instr_valid,
	input  wire [47:0] instr,
	input  wire [2:0]  instr_len,
	input  wire        supervisor_state,
	input  wire        problem_state,
	input  wire        wait_state,
	input  wire        xa_mode,
	input  wire        real_tick,
	input  wire        guest_ec_format,
	input  wire        guest_timer_int_en,
	input  wire        guest_page0_resident,
	input  wire        guest_ext_psw_valid,
	input  wire        guest_state_change_ok,
	input  wire        host_timer_int_en,
	input  wire        int_ack,
	output reg         exec_valid,
	output reg  [2:0]  exec_func,
	output reg         nop_done,
	output reg         op_exception,
	output reg         priv_exception,
	output reg         store_valid,
	output reg  [11:0] store_addr,
	output reg  [31:0] store_data,
	output reg         guest_int_req,
	output reg         host_int_req,
	output reg  [15:0] int_code
);
	// ==========================================================
	// Control register 6 and enables
	reg  [31:0] cr6;
	reg  [31:0] block_timer;
	reg         pending;
	reg         page0_q;
	reg  [7:0]  wait_div;
	wire        en_host_assist;
	wire        en_timer;
	wire        is_assist;
	wire [2:0]  func_sel;
	wire [1:0]  outcome;
	wire [31:0] vtimer;
	wire        crossed;
	wire        tick_dec;
	wire        wait_dec;
	wire        dec_en;
	wire        load_en;
	wire        guest_ok;
	wire        is_store_lvl;
	wire        len_ok;
	wire        feat_installed;
	wire        wr_ctrl6;
	wire        wr_block_tmr;
	wire [7:0]  next_wait_div;
	wire [31:0] status_word;

	// Function code handed to the routine engine, and the unknown code that is refused
	localparam [2:0] FUNC_STORE_LVL = 3'h4;
	localparam [2:0] FUNC_UNKNOWN   = 3'h7;

	// ==========================================================
	// Register write decode, shared by both writable words
	function hvat_wr_hit;
		input       wr;
		input [3:0] addr;
		input [3:0] target;
		begin
			hvat_wr_hit = wr && (addr == target);
		end
	endfunction

	// Write strobes of the two writable words
	assign wr_ctrl6     = hvat_wr_hit(reg_wr, reg_addr, `HVAT_REG_CTRL6);
	assign wr_block_tmr = hvat_wr_hit(reg_wr, reg_addr, `HVAT_REG_BLOCK_TMR);

	assign en_host_assist = xa_mode && cr6[`HVAT_CR6_BIT6_POS];
	// Timer needs bits 0 and 7
	assign en_timer = xa_mode && cr6[`HVAT_CR6_BIT0_POS] && cr6[`HVAT_CR6_BIT7_POS];

	// ==========================================================
	// Instruction classification
	// Length qualifier and build-time presence of the feature
	assign len_ok         = (instr_len == `HVAT_INSTR_BYTES);
	assign feat_installed = (FEATURE_INSTALLED != 0);

	hvat_decode u_decode (
		.instr             (instr),
		.instr_len_ok      (len_ok),
		.feature_installed (feat_installed),
		.host_assist_en    (en_host_assist),
		.supervisor_state  (supervisor_state),
		.is_assist         (is_assist),
		.func_sel          (func_sel),
		.outcome           (outcome)
	);

	assign is_store_lvl = (func_sel == FUNC_STORE_LVL);

	// Outcome pulses, one cycle after the instruction
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			exec_valid     <= 1'b0;
			exec_func      <= 3'h0;
			nop_done       <= 1'b0;
			op_exception   <= 1'b0;
			priv_exception <= 1'b0;
			store_valid    <= 1'b0;
			store_addr     <= 12'h000;
			store_data     <= 32'h0000_0000;
		end else begin
			exec_valid     <= 1'b0;
			nop_done       <= 1'b0;
			op_exception   <= 1'b0;
			priv_exception <= 1'b0;
			store_valid    <= 1'b0;
			if (instr_valid && is_assist) begin
				case (outcome)
					`HVAT_OUT_EXECUTE: begin
						if (func_sel == FUNC_UNKNOWN) begin
							op_exception <= 1'b1;
						end else begin
							exec_valid <= 1'b1;
							exec_func  <= func_sel;
						end
						if (is_store_lvl) begin
							store_valid <= 1'b1;
							store_addr  <= instr[27:16];
							store_data  <= LEVEL_ID;
						end
					end
					`HVAT_OUT_NOP:
						nop_done <= 1'b1;
					`HVAT_OUT_OPEXC:
						op_exception <= 1'b1;
					`HVAT_OUT_PRIV:
						priv_exception <= 1'b1;
					default:
						nop_done <= 1'b0;
				endcase
			end
		end
	end

	// ==========================================================
	// Virtual timer maintenance
	// Problem state real tick
	assign tick_dec = en_timer && problem_state && !wait_state && real_tick;
	assign wait_dec = en_timer && wait_state && real_tick && (wait_div == 8'h00);
	assign dec_en   = tick_dec || wait_dec;
	assign load_en  = guest_page0_resident && !page0_q;

	// Wait-rate divider wraps after the divide count
	assign next_wait_div = (wait_div == `HVAT_WAIT_DIV - 8'h01) ? 8'h00 : wait_div + 8'h01;

	// Divider only moves on wait-state ticks
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			wait_div <= 8'h00;
		else if (wait_state && real_tick)
			wait_div <= next_wait_div;
	end

	hvat_vtimer u_vtimer (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.dec_en   (dec_en),
		.load_en  (load_en),
		.load_val (block_timer),
		.timer    (vtimer),
		.crossed  (crossed)
	);

	// Control block copy tracks while page resident
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			page0_q     <= 1'b0;
			block_timer <= 32'h0000_0000;
		end else begin
			page0_q <= guest_page0_resident;
			if (wr_block_tmr)
				block_timer <= reg_wdata;
			else if (guest_page0_resident)
				block_timer <= vtimer;
			// Absent page: the kept word counts down in its place
			else if (dec_en)
				block_timer <= block_timer - `HVAT_VTIMER_STEP;
		end
	end

	// ==========================================================
	// Interruption presentation
	// Four guest conditions
	assign guest_ok = guest_timer_int_en && guest_page0_resident &&
		guest_ext_psw_valid && guest_state_change_ok;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pending       <= 1'b0;
			guest_int_req <= 1'b0;
			host_int_req  <= 1'b0;
			int_code      <= 16'h0000;
		end else begin
			guest_int_req <= 1'b0;
			host_int_req  <= 1'b0;
			// Crossing sets pending; set wins over clear
			if (crossed) begin
				pending <= 1'b1;
			end else if (pending && int_ack) begin
				pending <= 1'b0;
			end
			// Guest first, host as fallback, until acknowledged
			if (pending && !int_ack) begin
				if (guest_ok) begin
					guest_int_req <= 1'b1;
					int_code      <= `HVAT_EXT_CODE_REAL;
				end else if (host_timer_int_en) begin
					host_int_req <= 1'b1;
					int_code     <= `HVAT_EXT_CODE_VIRT;
				end
			end
		end
	end

	// ==========================================================
	// Register port
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cr6 <= `HVAT_CR6_RESET;
		end else if (wr_ctrl6) begin
			cr6 <= reg_wdata;
		end
	end

	// Status word: format, pending, timer, host assist, mode
	assign status_word = {27'h000_0000, guest_ec_format, pending, en_timer,
		en_host_assist, xa_mode};

	// Read data one cycle after the strobe
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`HVAT_REG_CTRL6:     reg_rdata <= cr6;
				`HVAT_REG_STATUS:    reg_rdata <= status_word;
				`HVAT_REG_VTIMER:    reg_rdata <= vtimer;
				`HVAT_REG_BLOCK_TMR: reg_rdata <= block_timer;
				`HVAT_REG_LEVEL:     reg_rdata <= LEVEL_ID;
				`HVAT_REG_INT_CODE:  reg_rdata <= {16'h0000, int_code};
				default:             reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule // hvat_top

// ==== hvat_top_tb.sv ====
`timescale 1ns/1ps
// ==========================================
// Self-checking bench for the assist block
module hvat_top_tb;
	logic        clk_sys, rst_n, reg_wr, reg_rd, instr_valid, supervisor_state;
	logic        problem_state, wait_state, xa_mode, real_tick, guest_ec_format;
	logic        guest_timer_int_en, guest_page0_resident, guest_ext_psw_valid;
	logic        guest_state_change_ok, host_timer_int_en, int_ack, exec_valid;
	logic        nop_done, op_exception, priv_exception, store_valid;
	logic        guest_int_req, host_int_req;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, store_data;
	logic [47:0] instr;
	logic [2:0]  instr_len, exec_func;
	logic [11:0] store_addr;
	logic [15:0] int_code;
	int          failures, samples_checked, i;

	hvat_top dut (.*);

	// ==========================================
	// Compare and bus tasks
	task chk(input logic [63:0] g, input logic [63:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task rchk(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	// Issue one assist; e is {exec,nop,opexc,priv}
	task ins(input logic [7:0] x, input logic [3:0] e);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr <= {8'hE6, x, 32'h0ABC_0000};
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		#1 chk({exec_valid, nop_done, op_exception, priv_exception}, e);
	endtask
	task tick;
		@(posedge clk_sys);
		real_tick <= 1'b1;
		@(posedge clk_sys);
		real_tick <= 1'b0;
	endtask
	task ack;
		@(posedge clk_sys);
		int_ack <= 1'b1;
		@(posedge clk_sys);
		int_ack <= 1'b0;
	endtask
	task close_out;
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Watchdog
	initial begin
		#20000;
		failures++;
		close_out;
	end
	// ==========================================
	// Main sequence
	initial begin
		{rst_n, reg_wr, reg_rd, instr_valid, problem_state, wait_state} = 6'h00;
		{xa_mode, real_tick, guest_ec_format, guest_page0_resident, int_ack} = 5'h00;
		{supervisor_state, guest_timer_int_en, guest_ext_psw_valid} = 3'h7;
		{guest_state_change_ok, host_timer_int_en} = 2'h3;
		{reg_addr, reg_wdata, instr, instr_len} = {36'h0, 48'h0, 3'h6};
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rchk(4'h0, 32'h0000_0000);
		wr(4'h0, 32'h8300_0000);
		rchk(4'h0, 32'h8300_0000);
		rchk(4'hF, 32'h0000_0000);
		ins(8'h00, 4'h4);
		@(posedge clk_sys) xa_mode <= 1'b1;
		for (i = 0; i < 7; i++) begin
			ins(i[7:0], 4'h8);
			chk(exec_func, i[2:0]);
		end
		ins(8'h04, 4'h8);
		chk({store_valid, store_addr, store_data}, {1'b1, 12'hABC, 32'h0000_0001});
		rchk(4'h4, 32'h0000_0001);
		ins(8'h07, 4'h2);
		@(posedge clk_sys) supervisor_state <= 1'b0;
		ins(8'h01, 4'h1);
		@(posedge clk_sys) supervisor_state <= 1'b1;
		wr(4'h0, 32'h8100_0000);
		ins(8'h02, 4'h4);
		// Guest delivery round
		wr(4'h3, 32'h0000_0180);
		@(posedge clk_sys) guest_page0_resident <= 1'b1;
		problem_state <= 1'b1;
		rchk(4'h2, 32'h0000_0180);
		tick;
		rchk(4'h2, 32'h0000_0080);
		tick;
		repeat (3) @(posedge clk_sys);
		#1 chk({guest_int_req, host_int_req, int_code}, {2'h2, 16'h0080});
		ack;
		repeat (3) @(posedge clk_sys);
		#1 chk({guest_int_req, host_int_req}, 2'h0);
		// Host delivery round, extended format guest
		@(posedge clk_sys) guest_page0_resident <= 1'b0;
		guest_timer_int_en <= 1'b0;
		guest_ec_format <= 1'b1;
		wr(4'h3, 32'h0000_0080);
		@(posedge clk_sys) guest_page0_resident <= 1'b1;
		tick;
		repeat (3) @(posedge clk_sys);
		#1 chk({guest_int_req, host_int_req, int_code}, {2'h1, 16'h0082});
		rchk(4'h1, 32'h0000_001D);
		rchk(4'h5, 32'h0000_0082);
		ack;
		// Divided rate in wait state
		@(posedge clk_sys) wait_state <= 1'b1;
		repeat (4) tick;
		rchk(4'h2, 32'hFFFF_FE80);
		// Mid-run reset must drop every enable again
		@(posedge clk_sys) rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rchk(4'h0, 32'h0000_0000);
		rchk(4'h1, 32'h0000_0011);
		close_out;
	end
endmodule // hvat_top_tb

bind hvat_top hvat_chk u_chk (.*);

// ==== hvat_vtimer.v ====
`timescale 1ns/1ps
`include "hvat_defs.vh"

// Virtual interval timer word with placement tracking
module hvat_vtimer (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        dec_en,
	input  wire        load_en,
	input  wire [31:0] load_val,
	output reg  [31:0] timer,
	output reg         crossed
);
	wire [31:0] next_timer;

	assign next_timer = timer - `HVAT_VTIMER_STEP;

	// ==========================================================
	// Decrement at bit 23 weight, flag positive-to-negative step
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timer   <= 32'h0000_0000;
			crossed <= 1'b0;
		end else if (load_en) begin
			timer   <= load_val;
			crossed <= 1'b0;
		end else if (dec_en) begin
			timer   <= next_timer;
			crossed <= !timer[31] && next_timer[31];
		end else begin
			crossed <= 1'b0;
		end
	end
endmodule // hvat_vtimer
